// >>> rtl/rrt_defines.vh
`ifndef RRT_DEFINES_VH
`define RRT_DEFINES_VH
// register indices; the byte address on the bus is index * 4
`define RRT_IDX_TS_LO      8'h64
`define RRT_IDX_TS_HI      8'h66
`define RRT_IDX_PIT_LO     8'h68
`define RRT_IDX_PIT_HI     8'h6A
`define RRT_IDX_CTRL       8'h6C
`define RRT_IDX_BTO_LO     8'h70
`define RRT_IDX_BTO_HI     8'h72
`define RRT_IDX_EVENT      8'h80
`define RRT_IDX_MASK       8'h82
`define RRT_ADDR_W         10
// control bit positions
`define RRT_C_RESV         0
`define RRT_C_RING_EN      1
`define RRT_C_SUPERVISOR   2
`define RRT_C_P1_RX_BLK    3
`define RRT_C_P1_TX_BLK    4
`define RRT_C_P2_RX_BLK    5
`define RRT_C_P2_TX_BLK    6
`define RRT_C_P1_BCN_HOST  7
`define RRT_C_P2_BCN_HOST  8
`define RRT_C_P1_BTO_EN    9
`define RRT_C_P2_BTO_EN    10
`define RRT_C_PIT_EN       11
`define RRT_C_CLR_SRCID    12
`define RRT_C_DROP_RSVD    13
`define RRT_C_ANNOUNCE     14
`define RRT_CTRL_WMASK     16'h7FFE
// event bit positions
`define RRT_E_PIT          0
`define RRT_E_BTO1         1
`define RRT_E_BTO2         2
`define RRT_RST16          16'h0000
`define RRT_RST32          32'h00000000
// timing: core clock 250 MHz, counter rates 100 MHz and 50 MHz
`define RRT_CLK_MHZ        250
`define RRT_FREE_MHZ       100
`define RRT_SLOW_MHZ       50
`define RRT_SLOW_DIV       (`RRT_CLK_MHZ / `RRT_SLOW_MHZ)
`endif

// >>> rtl/rrt_top.v
// Functional notes
// - 32-bit timestamp counter counting at 100 MHz
// - low read latches high half for later
// - 32-bit interval down counter at 50 MHz
// - enable rising loads reload, starts countdown
// - zero sets interval event and reloads
// - ring enable gates all ring handling
// - supervisor bit selects supervisor or node behaviour
// - receive block drops all but ring frames
// - blocked port still delivers check/status frames
// - node mode passes blocked-port beacons across
// - transmit block allows only two frame kinds
// - beacon-to-host bit forwards beacons, foreign always
// - per-port beacon timeout timer enable
// - clear-source-id pulses clear and self-clears on the same edge
// - drop reserved addresses between ports
// - announce bit delivers announce frames to host
// - interrupt when any event and its mask bit set
// - beacon timers 32-bit, 50 MHz, shared timeout
`timescale 1ns/1ns
`include "rrt_defines.vh"
module rrt_top (
   input  wire        CLOCK,
   input  wire        RST,
   input  wire [9:0]  AVS_ADDRESS,
   input  wire        AVS_READ,
   input  wire        AVS_WRITE,
   input  wire [31:0] AVS_WRITEDATA,
   input  wire [3:0]  AVS_BYTEENABLE,
   output reg  [31:0] AVS_READDATA,
   output reg         AVS_WAITREQUEST,
   input  wire        P1_BCN_SEEN,
   input  wire        P2_BCN_SEEN,
   input  wire [2:0]  FR_KIND,
   input  wire [1:0]  FR_RX_PORT,
   input  wire        FR_HOST_DA,
   input  wire        FR_FOREIGN_SA,
   input  wire        FR_RSVD_DA,
   input  wire [1:0]  FR_SRC_PORT,
   output reg         FWD_HOST,
   output reg         FWD_P1,
   output reg         FWD_P2,
   output reg         CLEAR_SRCID,
   output reg         IRQ
);
   // frame kinds
   localparam K_OTHER  = 3'h0;
   localparam K_BEACON = 3'h1;
   localparam K_NCHK   = 3'h2;
   localparam K_STATUS = 3'h3;
   localparam K_ANNC   = 3'h4;
   // ports: 0 host, 1 port1, 2 port2
   localparam PH = 2'h0;
   localparam P1 = 2'h1;
   localparam P2 = 2'h2;

   // =========================================================
   // rate enables
   // =========================================================
   // 100 MHz from 250 MHz: phase accumulator adds 2 of 5
   reg  [2:0] acc_q;
   reg        tick100_q;
   // 50 MHz: one clock in five
   reg  [2:0] div50_q;
   reg        tick50_q;
   always @(posedge CLOCK or posedge RST) begin
      if (RST) begin
         acc_q     <= 3'h0;
         tick100_q <= 1'b0;
         div50_q   <= 3'h0;
         tick50_q  <= 1'b0;
      end else begin
         if (acc_q >= 3'h3) begin
            acc_q     <= acc_q - 3'h3;
            tick100_q <= 1'b1;
         end else begin
            acc_q     <= acc_q + 3'h2;
            tick100_q <= 1'b0;
         end
         if (div50_q == 3'h4) begin
            div50_q  <= 3'h0;
            tick50_q <= 1'b1;
         end else begin
            div50_q  <= div50_q + 3'h1;
            tick50_q <= 1'b0;
         end
      end
   end

   // =========================================================
   // pin synchronisers
   // =========================================================
   // beacon pins are asynchronous: only the second stage feeds the edge detect
   reg [1:0] bs1_q;
   reg [1:0] bs2_q;
   reg       b1_prev_q;
   reg       b2_prev_q;
   always @(posedge CLOCK or posedge RST) begin
      if (RST) begin
         bs1_q     <= 2'h0;
         bs2_q     <= 2'h0;
         b1_prev_q <= 1'b0;
         b2_prev_q <= 1'b0;
      end else begin
         bs1_q     <= {bs1_q[0], P1_BCN_SEEN};
         bs2_q     <= {bs2_q[0], P2_BCN_SEEN};
         b1_prev_q <= bs1_q[1];
         b2_prev_q <= bs2_q[1];
      end
   end
   wire b1_rise = bs1_q[1] & ~b1_prev_q;
   wire b2_rise = bs2_q[1] & ~b2_prev_q;

   // =========================================================
   // registers and bus
   // =========================================================
   reg  [31:0] free_q;
   reg  [15:0] hold_q;
   reg  [15:0] pit_lo_q;
   reg  [15:0] pit_hi_q;
   reg  [15:0] bto_lo_q;
   reg  [15:0] bto_hi_q;
   reg  [15:0] ctrl_q;
   reg  [2:0]  evt_q;
   reg  [2:0]  mask_q;
   reg  [31:0] pit_cnt_q;
   reg  [31:0] bt1_cnt_q;
   reg  [31:0] bt2_cnt_q;
   reg         pit_en_q;
   reg         bt1_en_q;
   reg         bt2_en_q;
   reg         acc_phase_q;

   // one answer cycle per request; the phase bit stops the held request being retaken
   wire [7:0] idx = AVS_ADDRESS[9:2];
   wire       req = (AVS_READ | AVS_WRITE) & ~acc_phase_q;
   wire       wr  = AVS_WRITE & req & (AVS_BYTEENABLE[1:0] != 2'h0);
   wire [15:0] wd = AVS_WRITEDATA[15:0];
   wire       ev_clr = wr & (idx == `RRT_IDX_EVENT);

   function [15:0] merge16;
      input [15:0] old;
      input [15:0] nw;
      input [1:0]  be;
      begin
         merge16 = {be[1] ? nw[15:8] : old[15:8], be[0] ? nw[7:0] : old[7:0]};
      end
   endfunction

   function is_zero;
      input [31:0] cnt;
      begin
         is_zero = (cnt == 32'h00000000);
      end
   endfunction

   function [31:0] cdown;
      input [31:0] cnt;
      input [31:0] rld;
      begin
         cdown = is_zero(cnt) ? rld : cnt - 32'h00000001;
      end
   endfunction

   // picks the port1 or port2 copy of a per-port control bit
   function port_bit;
      input [1:0] port;
      input       bit_p1;
      input       bit_p2;
      begin
         port_bit = (port == P1) ? bit_p1 : bit_p2;
      end
   endfunction

   wire [31:0] pit_rld = {pit_hi_q, pit_lo_q};
   wire [31:0] bto_rld = {bto_hi_q, bto_lo_q};
   wire ring_en  = ctrl_q[`RRT_C_RING_EN];
   wire sup      = ctrl_q[`RRT_C_SUPERVISOR];
   wire drop_rsv = ctrl_q[`RRT_C_DROP_RSVD] & FR_RSVD_DA;
   // a counter only fires on the tick that finds it at zero
   wire pit_zero = pit_en_q & tick50_q & is_zero(pit_cnt_q);
   wire bt1_zero = bt1_en_q & tick50_q & is_zero(bt1_cnt_q);
   wire bt2_zero = bt2_en_q & tick50_q & is_zero(bt2_cnt_q);

   // a rising enable loads the count before any tick can reach zero
   wire pit_load = ctrl_q[`RRT_C_PIT_EN] & ~pit_en_q;
   wire bt1_load = (ctrl_q[`RRT_C_P1_BTO_EN] & ring_en & ~bt1_en_q) | (bt1_en_q & b1_rise);
   wire bt2_load = (ctrl_q[`RRT_C_P2_BTO_EN] & ring_en & ~bt2_en_q) | (bt2_en_q & b2_rise);

   always @(posedge CLOCK or posedge RST) begin
      if (RST) begin
         free_q          <= `RRT_RST32;
         hold_q          <= `RRT_RST16;
         pit_lo_q        <= `RRT_RST16;
         pit_hi_q        <= `RRT_RST16;
         bto_lo_q        <= `RRT_RST16;
         bto_hi_q        <= `RRT_RST16;
         ctrl_q          <= `RRT_RST16;
         evt_q           <= 3'h0;
         mask_q          <= 3'h0;
         AVS_READDATA    <= 32'h00000000;
         AVS_WAITREQUEST <= 1'b1;
         acc_phase_q     <= 1'b0;
         CLEAR_SRCID     <= 1'b0;
      end else begin
         if (tick100_q)
            free_q <= free_q + 32'h00000001;
         AVS_WAITREQUEST <= 1'b1;
         acc_phase_q     <= 1'b0;
         CLEAR_SRCID     <= 1'b0;
         // self-clearing bit never holds
         if (ctrl_q[`RRT_C_CLR_SRCID]) begin
            ctrl_q[`RRT_C_CLR_SRCID] <= 1'b0;
            CLEAR_SRCID              <= 1'b1;
         end
         if (req) begin
            acc_phase_q     <= 1'b1;
            AVS_WAITREQUEST <= 1'b0;
            AVS_READDATA    <= 32'h00000000;
            if (AVS_READ) begin
               case (idx)
                  `RRT_IDX_TS_LO: begin
                     AVS_READDATA[15:0] <= free_q[15:0];
                     hold_q             <= free_q[31:16];
                  end
                  `RRT_IDX_TS_HI:  AVS_READDATA[15:0] <= hold_q;
                  `RRT_IDX_PIT_LO: AVS_READDATA[15:0] <= pit_lo_q;
                  `RRT_IDX_PIT_HI: AVS_READDATA[15:0] <= pit_hi_q;
                  `RRT_IDX_CTRL:   AVS_READDATA[15:0] <= ctrl_q & `RRT_CTRL_WMASK
                                                         & ~(16'h0001 << `RRT_C_CLR_SRCID);
                  `RRT_IDX_BTO_LO: AVS_READDATA[15:0] <= bto_lo_q;
                  `RRT_IDX_BTO_HI: AVS_READDATA[15:0] <= bto_hi_q;
                  `RRT_IDX_EVENT:  AVS_READDATA[2:0]  <= evt_q;
                  `RRT_IDX_MASK:   AVS_READDATA[2:0]  <= mask_q;
                  default:         AVS_READDATA       <= 32'h00000000;
               endcase
            end else if (wr) begin
               case (idx)
                  `RRT_IDX_PIT_LO: pit_lo_q <= merge16(pit_lo_q, wd, AVS_BYTEENABLE[1:0]);
                  `RRT_IDX_PIT_HI: pit_hi_q <= merge16(pit_hi_q, wd, AVS_BYTEENABLE[1:0]);
                  `RRT_IDX_CTRL:   ctrl_q   <= merge16(ctrl_q, wd, AVS_BYTEENABLE[1:0])
                                               & `RRT_CTRL_WMASK;
                  `RRT_IDX_BTO_LO: bto_lo_q <= merge16(bto_lo_q, wd, AVS_BYTEENABLE[1:0]);
                  `RRT_IDX_BTO_HI: bto_hi_q <= merge16(bto_hi_q, wd, AVS_BYTEENABLE[1:0]);
                  `RRT_IDX_MASK:   mask_q   <= wd[2:0];
                  default: begin
                  end
               endcase
            end
         end
         // events: write one clears, a new set in the same cycle wins
         evt_q <= (ev_clr ? (evt_q & ~wd[2:0]) : evt_q)
                  | {bt2_zero, bt1_zero, pit_zero};
      end
   end

   // =========================================================
   // interval and beacon timeout timers
   // =========================================================
   always @(posedge CLOCK or posedge RST) begin
      if (RST) begin
         pit_cnt_q <= `RRT_RST32;
         bt1_cnt_q <= `RRT_RST32;
         bt2_cnt_q <= `RRT_RST32;
         pit_en_q  <= 1'b0;
         bt1_en_q  <= 1'b0;
         bt2_en_q  <= 1'b0;
      end else begin
         pit_en_q <= ctrl_q[`RRT_C_PIT_EN];
         bt1_en_q <= ctrl_q[`RRT_C_P1_BTO_EN] & ring_en;
         bt2_en_q <= ctrl_q[`RRT_C_P2_BTO_EN] & ring_en;
         if (pit_load)
            pit_cnt_q <= pit_rld;
         else if (pit_en_q & tick50_q)
            pit_cnt_q <= cdown(pit_cnt_q, pit_rld);
         if (bt1_load)
            bt1_cnt_q <= bto_rld;
         else if (bt1_en_q & tick50_q)
            bt1_cnt_q <= cdown(bt1_cnt_q, bto_rld);
         if (bt2_load)
            bt2_cnt_q <= bto_rld;
         else if (bt2_en_q & tick50_q)
            bt2_cnt_q <= cdown(bt2_cnt_q, bto_rld);
      end
   end

   // =========================================================
   // forwarding decision
   // =========================================================
   reg fh_d;
   reg f1_d;
   reg f2_d;
   reg rxb;
   reg bhost;
   reg other_txb;
   reg [1:0] other;
   always @* begin
      other     = (FR_RX_PORT == P1) ? P2 : P1;
      rxb       = port_bit(FR_RX_PORT, ctrl_q[`RRT_C_P1_RX_BLK], ctrl_q[`RRT_C_P2_RX_BLK]);
      bhost     = port_bit(FR_RX_PORT, ctrl_q[`RRT_C_P1_BCN_HOST], ctrl_q[`RRT_C_P2_BCN_HOST]);
      other_txb = port_bit(other, ctrl_q[`RRT_C_P1_TX_BLK], ctrl_q[`RRT_C_P2_TX_BLK]);
      fh_d = 1'b0;
      f1_d = 1'b0;
      f2_d = 1'b0;
      // host frames: a blocked transmit port takes only the permitted kinds
      if (FR_RX_PORT == PH) begin
         f1_d = 1'b1;
         f2_d = 1'b1;
         if (ring_en) begin
            if (ctrl_q[`RRT_C_P1_TX_BLK])
               f1_d = ((FR_KIND == K_BEACON) & sup)
                      | ((FR_KIND == K_NCHK) & (FR_SRC_PORT == P1));
            if (ctrl_q[`RRT_C_P2_TX_BLK])
               f2_d = ((FR_KIND == K_BEACON) & sup)
                      | ((FR_KIND == K_NCHK) & (FR_SRC_PORT == P2));
         end
      end else if (!ring_en) begin
         fh_d = FR_HOST_DA;
         if (!drop_rsv) begin
            f1_d = (other == P1) & ~FR_HOST_DA;
            f2_d = (other == P2) & ~FR_HOST_DA;
         end
      end else begin
         // ring enabled: ring frames escape a receive block
         case (FR_KIND)
            K_BEACON: begin
               fh_d = bhost | FR_FOREIGN_SA;
               if (!sup) begin
                  f1_d = (other == P1);
                  f2_d = (other == P2);
               end
            end
            K_NCHK:   fh_d = 1'b1;
            K_STATUS: fh_d = FR_HOST_DA;
            K_ANNC:   fh_d = ctrl_q[`RRT_C_ANNOUNCE];
            default: begin
               if (!rxb) begin
                  fh_d = FR_HOST_DA;
                  if (!drop_rsv & ~FR_HOST_DA & ~other_txb) begin
                     f1_d = (other == P1);
                     f2_d = (other == P2);
                  end
               end
            end
         endcase
         if (FR_KIND == K_ANNC && !rxb && !other_txb) begin
            f1_d = (other == P1);
            f2_d = (other == P2);
         end
      end
   end

   // =========================================================
   // registered outputs
   // =========================================================
   always @(posedge CLOCK or posedge RST) begin
      if (RST) begin
         FWD_HOST <= 1'b0;
         FWD_P1   <= 1'b0;
         FWD_P2   <= 1'b0;
         IRQ      <= 1'b0;
      end else begin
         FWD_HOST <= fh_d;
         FWD_P1   <= f1_d;
         FWD_P2   <= f2_d;
         IRQ      <= |(evt_q & mask_q);
      end
   end
endmodule

// >>> sim/rrt_checker.sv
`timescale 1ns/1ns
`include "rrt_defines.vh"
// ==========
// bus answer, self-clear and routing checks
module rrt_checker (
   input wire        CLOCK,
   input wire        RST,
   input wire [9:0]  AVS_ADDRESS,
   input wire        AVS_READ,
   input wire        AVS_WRITE,
   input wire [31:0] AVS_WRITEDATA,
   input wire [31:0] AVS_READDATA,
   input wire        AVS_WAITREQUEST,
   input wire [2:0]  FR_KIND,
   input wire [1:0]  FR_RX_PORT,
   input wire        FR_RSVD_DA,
   input wire        FWD_HOST,
   input wire        FWD_P1,
   input wire        FWD_P2,
   input wire        CLEAR_SRCID
);
   reg  [15:0] ctl_q;
   wire        wr_ctl;
   wire        rx1;
   // shadow of the control register, taken at each answered write to the control register
   assign wr_ctl = AVS_WRITE && !AVS_WAITREQUEST && AVS_ADDRESS[9:2] == `RRT_IDX_CTRL;
   assign rx1 = ctl_q[1] && ctl_q[3] && FR_RX_PORT == 2'h1;
   always @(posedge CLOCK or posedge RST) begin
      if (RST) begin
         ctl_q <= 16'h0000;
      end else if (wr_ctl) begin
         ctl_q <= AVS_WRITEDATA[15:0] & `RRT_CTRL_WMASK;
      end
   end
   default clocking @(posedge CLOCK); endclocking
   default disable iff (RST);
   property p_ans;
      $rose(AVS_READ || AVS_WRITE) |=> !AVS_WAITREQUEST;
   endproperty
   a_ans: assert property (p_ans) else $error("late answer");
   property p_one;
      !AVS_WAITREQUEST |=> AVS_WAITREQUEST;
   endproperty
   a_one: assert property (p_one) else $error("answer too long");
   property p_rsv;
      !AVS_WAITREQUEST && AVS_READ && AVS_ADDRESS[9:2] == `RRT_IDX_CTRL
         |-> AVS_READDATA[0] == 1'b0 && AVS_READDATA[12] == 1'b0;
   endproperty
   a_rsv: assert property (p_rsv) else $error("control readback bits");
   property p_clr;
      wr_ctl && AVS_WRITEDATA[12] |-> ##[0:2] CLEAR_SRCID;
   endproperty
   a_clr: assert property (p_clr) else $error("no clear pulse");
   property p_pls;
      CLEAR_SRCID |=> !CLEAR_SRCID;
   endproperty
   a_pls: assert property (p_pls) else $error("clear pulse too long");
   property p_rxb;
      rx1 && FR_KIND == 3'h0 |=> !FWD_HOST && !FWD_P2;
   endproperty
   a_rxb: assert property (p_rxb) else $error("blocked frame passed");
   property p_nck;
      rx1 && FR_KIND == 3'h2 |=> FWD_HOST;
   endproperty
   a_nck: assert property (p_nck) else $error("check frame not to host");
   property p_pass;
      rx1 && FR_KIND == 3'h1 && !ctl_q[2] |=> FWD_P2;
   endproperty
   a_pass: assert property (p_pass) else $error("node beacon not passed");
   property p_txb;
      ctl_q[1] && ctl_q[4] && FR_RX_PORT == 2'h0 && FR_KIND == 3'h0 |=> !FWD_P1;
   endproperty
   a_txb: assert property (p_txb) else $error("sent on blocked port");
   property p_drm;
      ctl_q[13] && FR_RSVD_DA && FR_RX_PORT == 2'h1 |=> !FWD_P2;
   endproperty
   a_drm: assert property (p_drm) else $error("reserved address forwarded");
   c_clr: cover property (wr_ctl && AVS_WRITEDATA[12] ##[1:2] CLEAR_SRCID);
   c_pass: cover property (rx1 && FR_KIND == 3'h1 ##1 FWD_P2);
   c_drm: cover property (ctl_q[13] && FR_RSVD_DA ##1 !FWD_P2);
endmodule
bind rrt_top rrt_checker i_rrt_checker (.CLOCK(CLOCK), .RST(RST), .AVS_ADDRESS(AVS_ADDRESS),
   .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE), .AVS_WRITEDATA(AVS_WRITEDATA),
   .AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST), .FR_KIND(FR_KIND),
   .FR_RX_PORT(FR_RX_PORT), .FR_RSVD_DA(FR_RSVD_DA), .FWD_HOST(FWD_HOST), .FWD_P1(FWD_P1),
   .FWD_P2(FWD_P2), .CLEAR_SRCID(CLEAR_SRCID));

// >>> sim/rrt_far_side.sv
`timescale 1ns/1ns
// ==========
// ring ports: frame class flags, port1 beacon pin pulsed on demand, port2 pin held low
module rrt_far_side (
   input  wire       clk,
   output reg  [2:0] kind,
   output reg  [1:0] rx_port,
   output reg  [2:0] flags,
   output reg  [1:0] src_port,
   output reg        bcn1,
   output reg        bcn2
);
   initial begin
      kind = 3'h0;
      rx_port = 2'h3;
      flags = 3'h0;
      src_port = 2'h0;
      bcn1 = 1'b0;
      bcn2 = 1'b0;
   end
   // hold one frame for two edges so its decision can be seen
   task frame(input [2:0] k, input [1:0] p, input [2:0] f, input [1:0] s);
      @(posedge clk);
      kind <= k;
      rx_port <= p;
      flags <= f;
      src_port <= s;
      repeat (2) @(posedge clk);
   endtask
   // one valid port1 beacon: pin high for two edges, then quiet
   task beacon;
      @(posedge clk);
      bcn1 <= 1'b1;
      repeat (2) @(posedge clk);
      bcn1 <= 1'b0;
      repeat (6) @(posedge clk);
   endtask
   // between frames no port is named and flags keep moving
   task idle;
      @(posedge clk);
      rx_port <= 2'h3;
      flags <= ~flags;
   endtask
endmodule

// >>> sim/rrt_top_bench.sv
`timescale 1ns/1ns
`include "rrt_defines.vh"
// ==========
// register, timer and routing tests
module rrt_top_bench;
   reg         CLOCK = 1'b0;
   reg         RST = 1'b1;
   reg  [9:0]  AVS_ADDRESS = 10'h000;
   reg         AVS_READ = 1'b0;
   reg         AVS_WRITE = 1'b0;
   reg  [31:0] AVS_WRITEDATA = 32'h00000000;
   reg  [3:0]  AVS_BYTEENABLE = 4'h3;
   wire [31:0] AVS_READDATA;
   wire        AVS_WAITREQUEST;
   wire [2:0]  kind;
   wire [2:0]  fl;
   wire [1:0]  rx_port;
   wire [1:0]  src_port;
   wire        bcn1;
   wire        bcn2;
   wire        FWD_HOST;
   wire        FWD_P1;
   wire        FWD_P2;
   wire        CLEAR_SRCID;
   wire        IRQ;
   wire [2:0]  fw = {FWD_HOST, FWD_P1, FWD_P2};
   integer     err_count = 0;
   integer     check_count = 0;
   integer     cyc = 0;
   integer     clr_n = 0;
   integer     n;
   integer     i;
   reg  [31:0] q;
   reg  [15:0] t0;
   reg  [15:0] ctl;
   reg  [31:0] tbl [0:15];
   reg  [47:0] rl = {8'h66, 8'h68, 8'h6A, 8'h6C, 8'h82, 8'h90};
   rrt_top i_rrt_top (.CLOCK(CLOCK), .RST(RST), .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ),
      .AVS_WRITE(AVS_WRITE), .AVS_WRITEDATA(AVS_WRITEDATA), .AVS_BYTEENABLE(AVS_BYTEENABLE),
      .AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST), .P1_BCN_SEEN(bcn1),
      .P2_BCN_SEEN(bcn2), .FR_KIND(kind), .FR_RX_PORT(rx_port), .FR_HOST_DA(fl[2]),
      .FR_FOREIGN_SA(fl[1]), .FR_RSVD_DA(fl[0]), .FR_SRC_PORT(src_port), .FWD_HOST(FWD_HOST),
      .FWD_P1(FWD_P1), .FWD_P2(FWD_P2), .CLEAR_SRCID(CLEAR_SRCID), .IRQ(IRQ));
   rrt_far_side i_rrt_far_side (.clk(CLOCK), .kind(kind), .rx_port(rx_port), .flags(fl),
      .src_port(src_port), .bcn1(bcn1), .bcn2(bcn2));
   always #2 CLOCK = ~CLOCK;
   always @(posedge CLOCK) begin
      cyc = cyc + 1;
      if (CLEAR_SRCID === 1'b1) begin
         clr_n = clr_n + 1;
      end
      if (cyc > 20000) begin
         err_count = err_count + 1;
         close_out;
      end
   end
   task close_out;
      $display("checks %0d mismatches %0d", check_count, err_count);
      if (err_count == 0 && check_count > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      check_count = check_count + 1;
      if (seen !== exp) begin
         err_count = err_count + 1;
         $display("unexpected %0s expected %h seen %h", nm, exp, seen);
      end
   endtask
   // one access, held until the answer edge
   task automatic bus(input logic wr, input logic [7:0] idx, input logic [15:0] d);
      @(posedge CLOCK);
      AVS_ADDRESS <= {idx, 2'b00};
      AVS_WRITEDATA <= {16'h0000, d};
      AVS_WRITE <= wr;
      AVS_READ <= !wr;
      @(posedge CLOCK);
      while (AVS_WAITREQUEST !== 1'b0) begin
         @(posedge CLOCK);
      end
      q = AVS_READDATA;
      AVS_WRITE <= 1'b0;
      AVS_READ <= 1'b0;
   endtask
   task automatic wait_irq;
      n = 0;
      repeat (3) @(posedge CLOCK);
      while (IRQ !== 1'b1 && n < 60) begin
         @(posedge CLOCK);
         n = n + 1;
      end
   endtask
   initial begin
      tbl[0] = {16'h004A, 16'h0805};
      tbl[1] = {16'h004A, 16'h280D};
      tbl[2] = {16'h004A, 16'h2A24};
      tbl[3] = {16'h004A, 16'h4825};
      tbl[4] = {16'h004A, 16'h6C25};
      tbl[5] = {16'h004A, 16'h6805};
      tbl[6] = {16'h008E, 16'h2825};
      tbl[7] = {16'h0016, 16'h2012};
      tbl[8] = {16'h0016, 16'h0002};
      tbl[9] = {16'h0016, 16'h4052};
      tbl[10] = {16'h0016, 16'h4082};
      tbl[11] = {16'h0016, 16'h3002};
      tbl[12] = {16'h6002, 16'h0901};
      tbl[13] = {16'h6002, 16'h1102};
      tbl[14] = {16'h6002, 16'h8824};
      tbl[15] = {16'h0008, 16'h0809};
      repeat (16) @(posedge CLOCK);
      RST <= 1'b0;
      for (i = 0; i < 6; i = i + 1) begin
         bus(1'b0, rl[40 - i * 8 +: 8], 16'h0000);
         chk("reset value", q, 32'h00000000);
      end
      bus(1'b1, `RRT_IDX_PIT_LO, 16'hA5C3);
      bus(1'b1, `RRT_IDX_PIT_HI, 16'h5A3C);
      bus(1'b0, `RRT_IDX_PIT_LO, 16'h0000);
      chk("reload low", q, 32'h0000A5C3);
      bus(1'b0, `RRT_IDX_PIT_HI, 16'h0000);
      chk("reload high", q, 32'h00005A3C);
      AVS_BYTEENABLE <= 4'h1;
      bus(1'b1, `RRT_IDX_PIT_LO, 16'hFFFF);
      AVS_BYTEENABLE <= 4'h3;
      bus(1'b0, `RRT_IDX_PIT_LO, 16'h0000);
      chk("lane write", q, 32'h0000A5FF);
      $display("register test done");
      bus(1'b0, `RRT_IDX_TS_LO, 16'h0000);
      t0 = q[15:0];
      repeat (100) @(posedge CLOCK);
      bus(1'b0, `RRT_IDX_TS_LO, 16'h0000);
      n = q[15:0] - t0;
      chk("stamp step", {31'h0, n == 41 || n == 42}, 32'h1);
      bus(1'b0, `RRT_IDX_TS_HI, 16'h0000);
      chk("stamp high", q, 32'h00000000);
      $display("timestamp test done");
      bus(1'b1, `RRT_IDX_CTRL, 16'hFFFF);
      bus(1'b0, `RRT_IDX_CTRL, 16'h0000);
      chk("control", q, 32'h00006FFE);
      chk("clear pulses", clr_n, 32'h1);
      $display("control test done");
      ctl = 16'hFFFF;
      for (i = 0; i < 16; i = i + 1) begin
         if (tbl[i][31:16] != ctl) begin
            i_rrt_far_side.idle;
            ctl = tbl[i][31:16];
            bus(1'b1, `RRT_IDX_CTRL, ctl);
         end
         i_rrt_far_side.frame(tbl[i][15:13], tbl[i][12:11], tbl[i][10:8], tbl[i][7:6]);
         chk("route", {29'h0, fw & tbl[i][2:0]}, {29'h0, tbl[i][5:3] & tbl[i][2:0]});
      end
      i_rrt_far_side.idle;
      bus(1'b0, `RRT_IDX_EVENT, 16'h0000);
      chk("timeout events", q, 32'h00000006);
      bus(1'b1, `RRT_IDX_EVENT, 16'h0006);
      $display("routing test done");
      bus(1'b1, `RRT_IDX_PIT_LO, 16'h0003);
      bus(1'b1, `RRT_IDX_PIT_HI, 16'h0000);
      bus(1'b1, `RRT_IDX_MASK, 16'h0001);
      bus(1'b1, `RRT_IDX_CTRL, 16'h0800);
      wait_irq;
      chk("first event", {31'h0, n < 60}, 32'h1);
      bus(1'b1, `RRT_IDX_EVENT, 16'h0001);
      wait_irq;
      chk("interval", {31'h0, n >= 12 && n <= 16}, 32'h1);
      bus(1'b1, `RRT_IDX_MASK, 16'h0000);
      repeat (3) @(posedge CLOCK);
      chk("masked irq", {31'h0, IRQ}, 32'h0);
      bus(1'b0, `RRT_IDX_EVENT, 16'h0000);
      chk("event", q, 32'h00000001);
      bus(1'b1, `RRT_IDX_CTRL, 16'h0000);
      bus(1'b1, `RRT_IDX_EVENT, 16'h0001);
      repeat (40) @(posedge CLOCK);
      bus(1'b0, `RRT_IDX_EVENT, 16'h0000);
      chk("stopped", q, 32'h00000000);
      $display("interval test done");
      bus(1'b1, `RRT_IDX_BTO_LO, 16'h0004);
      bus(1'b1, `RRT_IDX_CTRL, 16'h0202);
      for (i = 0; i < 6; i = i + 1) begin
         i_rrt_far_side.beacon;
      end
      bus(1'b0, `RRT_IDX_EVENT, 16'h0000);
      chk("beacon reload", q, 32'h00000000);
      repeat (40) @(posedge CLOCK);
      bus(1'b0, `RRT_IDX_EVENT, 16'h0000);
      chk("beacon timeout", q, 32'h00000002);
      bus(1'b1, `RRT_IDX_CTRL, 16'h0000);
      $display("beacon test done");
      close_out;
   end
endmodule
